// file: verilog/scp_clock_power.sv
// system clock source selection and low-power mode control
//
// What this block does
// [R1] stop bit halts processor and fast oscillator; reads as zero
// [R2] idle bit gates processor clock only; reads as zero
// [R3] six upper power bits are plain scratch flags, reset zero
// [R4] source code picks fast/div, external, slow/div, fast direct, low-power
// [R5] source may change while running; software selects only settled sources
// [R6] external oscillator tick stays available to timers and counter array
// [R7] low-power oscillator runs while it is the selected source or the mux still uses it
// [R8] fast and slow oscillators usable right after the enabling write
// [R9] crystal valid flag set once the external crystal settles
// [R10] software waits 1 ms after enabling crystal before reading valid flag
// [R11] reset returns source code to divided fast oscillator
// [R12] fast path divides by 2, 4, 8 or 16, sixteen after reset
// [R13] suspend bit stops fast oscillator; clocks halt when it drives system
// [R14] wake on port 0 match, port 1 match, comparator low, timer 3 overflow
// [R15] wake resumes everything, with or without interrupt
// [R16] seven-bit trim sets oscillator period, zero fastest, reset value trimmed
// [R17] unused upper bits read zero and ignore writes
// [R18] divider code 00 is 16, 01 is 8, 10 is 4, 11 is 2
// [R19] software selects fast oscillator before requesting stop
// [R20] idle ends on enabled interrupt or reset, idle request cleared
// [R21] mode requests act only after the setting instruction completes
// [R22] source switch makes no truncated or glitch pulses
`timescale 1ns/1ns
module scp_clock_power
    import scp_pkg::*;
#(
    parameter logic [6:0] TRIM_RESET = 7'h40   // factory trim stand-in, arbitrary
)
(
    // clock and reset
    input  wire logic       CLK_I,
    input  wire logic       RST_I,
    // special function register port
    input  wire logic [7:0] SFR_ADDR_I,
    input  wire logic [7:0] SFR_WDATA_I,
    input  wire logic       SFR_WR_I,
    input  wire logic       SFR_RD_I,
    output logic [7:0]      SFR_RDATA_O,
    // processor status
    input  wire logic       INSTR_DONE_I,
    input  wire logic       IRQ_PENDING_I,
    // suspend wake events
    input  wire logic       PORT0_MATCH_I,
    input  wire logic       PORT1_MATCH_I,
    input  wire logic       CMP0_ENABLED_I,
    input  wire logic       CMP0_OUT_I,
    input  wire logic       TMR3_OVF_I,
    // oscillator ticks, one cycle each
    input  wire logic       FAST_OSC_TICK_I,
    input  wire logic       EXT_OSC_TICK_I,
    input  wire logic       SLOW_OSC_TICK_I,
    input  wire logic       LOWPWR_OSC_TICK_I,
    input  wire logic       XTAL_SETTLED_I,
    // oscillator controls
    output logic            FAST_OSC_RUN_O,
    output logic            LOWPWR_OSC_EN_O,
    output logic [6:0]      FAST_OSC_TRIM_O,
    output logic            CRYSTAL_VALID_O,
    // clocks to the rest of the device
    output logic            SYSTEM_CLOCK_O,
    output logic            CPU_CLOCK_O,
    output logic            PERIPH_CLOCK_O,
    output logic            EXT_TIMER_TICK_O,
    output logic [3:0]      POWER_MODE_O
);

    initial
    begin
        if (TRIM_RESET > 7'h7F)
            $error("trim reset value out of range");
    end

    // ****************************************
    // register state
    // ****************************************
    logic [5:0]             scratch_flags_r;
    logic [2:0]             clock_source_code_r;
    logic                   fast_osc_enable_r;
    logic                   suspend_r;
    logic [1:0]             fast_osc_divider_code_r;
    logic [6:0]             fast_oscillator_trim_r;
    logic                   stop_pend_r;
    logic                   idle_pend_r;
    logic                   susp_pend_r;
    scp_pm_e                pm_r;
    scp_pm_e                pm_nxt;
    logic [7:0]             rdata_nxt;

    // ****************************************
    // write strobes and wake logic
    // ****************************************
    logic                   wr_pmc_w;
    logic                   wr_sel_w;
    logic                   wr_foc_w;
    logic                   wr_trim_w;
    logic                   wake_w;
    logic                   fast_is_sys_w;
    logic [SCP_NUM_SRC-1:0] sel_vec_w;
    logic [SCP_NUM_SRC-1:0] cur_vec_w;
    logic [SCP_NUM_SRC-1:0] ticks_w;
    logic                   fast_tick_w;
    logic                   div_tick_w;
    logic                   sys_tick_w;

    assign wr_pmc_w  = SFR_WR_I && SFR_ADDR_I == SCP_ADDR_POWER_MODE_CONTROL;
    assign wr_sel_w  = SFR_WR_I && SFR_ADDR_I == SCP_ADDR_CLOCK_SOURCE_SEL;
    assign wr_foc_w  = SFR_WR_I && SFR_ADDR_I == SCP_ADDR_FAST_OSC_CONTROL;
    assign wr_trim_w = SFR_WR_I && SFR_ADDR_I == SCP_ADDR_FAST_OSC_TRIM;

    // any of the four wake sources
    assign wake_w = PORT0_MATCH_I || PORT1_MATCH_I
                 || (CMP0_ENABLED_I && !CMP0_OUT_I) || TMR3_OVF_I;   // see [R14]

    // ****************************************
    // power control register
    // ****************************************

    // scratch flags: storage only
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            scratch_flags_r <= SCP_FLAGS_RESET;
        else if (wr_pmc_w)
            scratch_flags_r <= SFR_WDATA_I[7:SCP_PMC_FLAGS_LSB];   // see [R3]
    end

    // stop and idle requests wait for the instruction to finish
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            stop_pend_r <= 1'b0;
            idle_pend_r <= 1'b0;
        end
        else
        begin
            if (wr_pmc_w && SFR_WDATA_I[SCP_PMC_STOP_BIT])
                stop_pend_r <= 1'b1;
            else if (INSTR_DONE_I)
                stop_pend_r <= 1'b0;   // see [R21]
            if (wr_pmc_w && SFR_WDATA_I[SCP_PMC_IDLE_BIT])
                idle_pend_r <= 1'b1;
            else if (INSTR_DONE_I)
                idle_pend_r <= 1'b0;   // see [R21]
        end
    end

    // ****************************************
    // clock source select register
    // ****************************************

    // reserved codes are ignored so the mux never loses its source
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            clock_source_code_r <= SCP_SRC_FAST_DIV;   // see [R11]
        else if (wr_sel_w && scp_src_decode(SFR_WDATA_I[2:0]) != '0)
            clock_source_code_r <= SFR_WDATA_I[2:0];   // see [R4] see [R17]
    end

    // ****************************************
    // fast oscillator control and trim
    // ****************************************

    // enable bit and divider code
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            fast_osc_enable_r       <= SCP_FAST_EN_RESET;
            fast_osc_divider_code_r <= SCP_DIV_CODE_RESET;   // see [R12]
        end
        else if (wr_foc_w)
        begin
            fast_osc_enable_r       <= SFR_WDATA_I[SCP_FOC_ENABLE_BIT];
            fast_osc_divider_code_r <= SFR_WDATA_I[1:0];   // see [R18]
        end
    end

    // suspend bit: set by write, cleared by a wake while suspended
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            suspend_r   <= 1'b0;
            susp_pend_r <= 1'b0;
        end
        else
        begin
            if (wr_foc_w && SFR_WDATA_I[SCP_FOC_SUSPEND_BIT])
                suspend_r <= 1'b1;   // see [R13]
            else if (pm_r == SCP_PM_SUSPEND && wake_w)
                suspend_r <= 1'b0;   // see [R15]
            if (wr_foc_w && SFR_WDATA_I[SCP_FOC_SUSPEND_BIT])
                susp_pend_r <= 1'b1;
            else if (INSTR_DONE_I)
                susp_pend_r <= 1'b0;   // see [R21]
        end
    end

    // trim value, bit 7 not stored
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            fast_oscillator_trim_r <= TRIM_RESET;   // see [R16]
        else if (wr_trim_w)
            fast_oscillator_trim_r <= SFR_WDATA_I[6:0];   // see [R17]
    end

    // ****************************************
    // power mode state machine
    // ****************************************

    // next power mode
    always_comb
    begin
        pm_nxt = pm_r;
        case (pm_r)
            SCP_PM_RUN:
            begin
                if (INSTR_DONE_I && stop_pend_r)
                    pm_nxt = SCP_PM_STOP;   // see [R1] see [R21]
                else if (INSTR_DONE_I && susp_pend_r)
                    pm_nxt = SCP_PM_SUSPEND;   // see [R13] see [R21]
                else if (INSTR_DONE_I && idle_pend_r)
                    pm_nxt = SCP_PM_IDLE;   // see [R2] see [R21]
            end
            SCP_PM_IDLE:
            begin
                if (IRQ_PENDING_I)
                    pm_nxt = SCP_PM_RUN;   // see [R20]
            end
            SCP_PM_STOP:
                pm_nxt = SCP_PM_STOP;   // only reset leaves stop
            SCP_PM_SUSPEND:
            begin
                if (wake_w)
                    pm_nxt = SCP_PM_RUN;   // see [R15]
            end
            default:
                pm_nxt = SCP_PM_RUN;
        endcase
    end

    // power mode register
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            pm_r <= SCP_PM_RUN;   // see [R20]
        else
            pm_r <= pm_nxt;
    end

    // ****************************************
    // oscillators and system clock
    // ****************************************

    // fast oscillator stops in stop and suspend, no settle wait otherwise
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            FAST_OSC_RUN_O <= 1'b0;
        else
            FAST_OSC_RUN_O <= fast_osc_enable_r && pm_nxt != SCP_PM_STOP
                           && pm_nxt != SCP_PM_SUSPEND;   // see [R1] see [R8] see [R13]
    end

    assign fast_tick_w = FAST_OSC_TICK_I && FAST_OSC_RUN_O;
    assign sel_vec_w   = scp_src_decode(clock_source_code_r);
    assign ticks_w     = {LOWPWR_OSC_TICK_I, fast_tick_w, SLOW_OSC_TICK_I, EXT_OSC_TICK_I, div_tick_w};

    // low-power oscillator follows selection and mux use
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            LOWPWR_OSC_EN_O <= 1'b0;
        else
            LOWPWR_OSC_EN_O <= sel_vec_w[4] || cur_vec_w[4];   // see [R7]
    end

    // fast divider
    scp_fast_divider u_fast_divider
    (
        .clk_i       (CLK_I),
        .rst_i       (RST_I),
        .div_code_i  (fast_osc_divider_code_r),
        .fast_tick_i (fast_tick_w),
        .div_tick_o  (div_tick_w)
    );

    // source mux
    scp_source_mux #(
        .NUM_SRC (SCP_NUM_SRC)
    ) u_source_mux
    (
        .clk_i      (CLK_I),
        .rst_i      (RST_I),
        .sel_i      (sel_vec_w),
        .tick_i     (ticks_w),
        .cur_o      (cur_vec_w),
        .sys_tick_o (sys_tick_w)
    );

    assign fast_is_sys_w = cur_vec_w[0] || cur_vec_w[3];

    // clock pulses to processor and peripherals
    assign SYSTEM_CLOCK_O = sys_tick_w;
    assign CPU_CLOCK_O    = sys_tick_w && pm_r == SCP_PM_RUN;   // see [R2]
    assign PERIPH_CLOCK_O = sys_tick_w && pm_r != SCP_PM_STOP
                         && !(pm_r == SCP_PM_SUSPEND && fast_is_sys_w);   // see [R2] see [R13]
    assign POWER_MODE_O   = pm_r;

    // external tick to timers and counter array, any selection
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            EXT_TIMER_TICK_O <= 1'b0;
        else
            EXT_TIMER_TICK_O <= EXT_OSC_TICK_I;   // see [R6]
    end

    // crystal valid flag
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            CRYSTAL_VALID_O <= 1'b0;
        else
            CRYSTAL_VALID_O <= XTAL_SETTLED_I;   // see [R9]
    end

    assign FAST_OSC_TRIM_O = fast_oscillator_trim_r;

    // ****************************************
    // register read
    // ****************************************

    // read mux, idle and stop request bits always zero
    always_comb
    begin
        rdata_nxt = SCP_READ_ZERO;
        if (SFR_ADDR_I == SCP_ADDR_POWER_MODE_CONTROL)
            rdata_nxt = {scratch_flags_r, 2'b00};   // see [R1] see [R2]
        else if (SFR_ADDR_I == SCP_ADDR_CLOCK_SOURCE_SEL)
            rdata_nxt = {5'b00000, clock_source_code_r};   // see [R17]
        else if (SFR_ADDR_I == SCP_ADDR_FAST_OSC_CONTROL)
            rdata_nxt = {fast_osc_enable_r, FAST_OSC_RUN_O, suspend_r, 3'b000,
                         fast_osc_divider_code_r};
        else if (SFR_ADDR_I == SCP_ADDR_FAST_OSC_TRIM)
            rdata_nxt = {1'b0, fast_oscillator_trim_r};   // see [R17]
    end

    // read data register
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            SFR_RDATA_O <= SCP_READ_ZERO;
        else if (SFR_RD_I)
            SFR_RDATA_O <= rdata_nxt;
    end

endmodule // scp_clock_power

// file: verilog/scp_pkg.sv
// shared constants for the system clock and power control block
package scp_pkg;

    // ****************************************
    // register addresses
    // ****************************************
    localparam logic [7:0] SCP_ADDR_POWER_MODE_CONTROL = 8'h87;
    localparam logic [7:0] SCP_ADDR_CLOCK_SOURCE_SEL   = 8'hA9;
    localparam logic [7:0] SCP_ADDR_FAST_OSC_CONTROL   = 8'hB2;
    localparam logic [7:0] SCP_ADDR_FAST_OSC_TRIM      = 8'hB3;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int         SCP_PMC_IDLE_BIT     = 0;
    localparam int         SCP_PMC_STOP_BIT     = 1;
    localparam int         SCP_PMC_FLAGS_LSB    = 2;
    localparam int         SCP_FOC_SUSPEND_BIT  = 5;
    localparam int         SCP_FOC_ENABLE_BIT   = 7;
    localparam logic [5:0] SCP_FLAGS_RESET      = 6'h00;
    localparam logic [1:0] SCP_DIV_CODE_RESET   = 2'h0;
    localparam logic       SCP_FAST_EN_RESET    = 1'b1;
    localparam logic [7:0] SCP_READ_ZERO        = 8'h00;

    // ****************************************
    // clock source codes
    // ****************************************
    localparam logic [2:0] SCP_SRC_FAST_DIV   = 3'h0;
    localparam logic [2:0] SCP_SRC_EXTERNAL   = 3'h1;
    localparam logic [2:0] SCP_SRC_SLOW_DIV   = 3'h2;
    localparam logic [2:0] SCP_SRC_FAST_DIRECT = 3'h3;
    localparam logic [2:0] SCP_SRC_LOW_POWER  = 3'h5;
    localparam int         SCP_NUM_SRC        = 5;

    // ****************************************
    // divider: ratio is 16 shifted right by the code
    // ****************************************
    localparam logic [4:0] SCP_DIV_MAX_RATIO  = 5'h10;

    // ****************************************
    // power mode states
    // ****************************************
    typedef enum logic [3:0] {
        SCP_PM_RUN     = 4'h1,
        SCP_PM_IDLE    = 4'h2,
        SCP_PM_STOP    = 4'h4,
        SCP_PM_SUSPEND = 4'h8
    } scp_pm_e;

    // maps a source code to a one-hot source vector, zero when reserved
    function automatic logic [SCP_NUM_SRC-1:0] scp_src_decode(input logic [2:0] code);
        logic [SCP_NUM_SRC-1:0] v;
        v = '0;
        if (code == SCP_SRC_FAST_DIV)
            v[0] = 1'b1;
        else if (code == SCP_SRC_EXTERNAL)
            v[1] = 1'b1;
        else if (code == SCP_SRC_SLOW_DIV)
            v[2] = 1'b1;
        else if (code == SCP_SRC_FAST_DIRECT)
            v[3] = 1'b1;
        else if (code == SCP_SRC_LOW_POWER)
            v[4] = 1'b1;
        return v;
    endfunction

endpackage

// file: verilog/scp_fast_divider.sv
// divider of the fast oscillator tick by 2, 4, 8 or 16
`timescale 1ns/1ns
module scp_fast_divider
    import scp_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // control and ticks
    input  wire logic [1:0] div_code_i,
    input  wire logic       fast_tick_i,
    output logic            div_tick_o
);

    logic [3:0] cnt_r;
    logic [3:0] last_w;

    // last count of a period: ratio minus one
    assign last_w = 4'((SCP_DIV_MAX_RATIO >> div_code_i) - 5'h01);

    // count fast ticks, pulse once per period
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_r      <= 4'h0;
            div_tick_o <= 1'b0;
        end
        else
        begin
            div_tick_o <= 1'b0;
            if (fast_tick_i)
            begin
                if (cnt_r >= last_w)   // shrinking ratio ends period now
                begin
                    cnt_r      <= 4'h0;
                    div_tick_o <= 1'b1;
                end
                else
                    cnt_r <= cnt_r + 4'h1;
            end
        end
    end

endmodule // scp_fast_divider

// file: verilog/scp_source_mux.sv
// glitch-free selection of the system clock tick among five sources
`timescale 1ns/1ns
module scp_source_mux
    import scp_pkg::*;
#(
    parameter int NUM_SRC = SCP_NUM_SRC
)
(
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // selection and source ticks
    input  wire logic [NUM_SRC-1:0] sel_i,
    input  wire logic [NUM_SRC-1:0] tick_i,
    output logic [NUM_SRC-1:0]      cur_o,
    output logic                    sys_tick_o
);

    initial
    begin
        if (NUM_SRC != SCP_NUM_SRC)
            $error("source count must match the source codes");
    end

    logic cur_busy_w;
    logic new_busy_w;

    assign cur_busy_w = |(cur_o & tick_i);
    assign new_busy_w = |(sel_i & tick_i);

    // change source only in a quiet cycle of both old and new source
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cur_o <= NUM_SRC'(1);
        else if (sel_i != cur_o && !cur_busy_w && !new_busy_w)   // see [R22] see [R5]
            cur_o <= sel_i;
    end

    // whole pulses of the current source only
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sys_tick_o <= 1'b0;
        else
            sys_tick_o <= cur_busy_w;   // see [R4]
    end

endmodule // scp_source_mux

// file: sim/scp_clock_power_checker.sv
// assertion checker for the clock and power control block
`timescale 1ns/1ns
module scp_clock_power_checker
(
    // clock and reset
    input wire logic       CLK_I,
    input wire logic       RST_I,
    // register port and processor status
    input wire logic       SFR_RD_I,
    input wire logic [7:0] SFR_RDATA_O,
    input wire logic       INSTR_DONE_I,
    input wire logic       IRQ_PENDING_I,
    // wake events and sources
    input wire logic       PORT0_MATCH_I,
    input wire logic       PORT1_MATCH_I,
    input wire logic       CMP0_ENABLED_I,
    input wire logic       CMP0_OUT_I,
    input wire logic       TMR3_OVF_I,
    input wire logic       EXT_OSC_TICK_I,
    input wire logic       XTAL_SETTLED_I,
    // watched outputs
    input wire logic       FAST_OSC_RUN_O,
    input wire logic       CRYSTAL_VALID_O,
    input wire logic       SYSTEM_CLOCK_O,
    input wire logic       CPU_CLOCK_O,
    input wire logic       PERIPH_CLOCK_O,
    input wire logic       EXT_TIMER_TICK_O,
    input wire logic [3:0] POWER_MODE_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    // any suspend wake event
    logic wake;
    assign wake = PORT0_MATCH_I || PORT1_MATCH_I || TMR3_OVF_I || (CMP0_ENABLED_I && !CMP0_OUT_I);

    // ********************
    // properties
    // ********************
    property p_stop_hold;
        POWER_MODE_O == 4'h4 |=> (POWER_MODE_O == 4'h4)[*3];
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop left");
    property p_osc_off;
        (POWER_MODE_O[2] || POWER_MODE_O[3]) |-> !FAST_OSC_RUN_O;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("osc runs");
    property p_cpu_gate;
        CPU_CLOCK_O == (SYSTEM_CLOCK_O && POWER_MODE_O == 4'h1);
    endproperty
    a_cpu_gate: assert property (p_cpu_gate) else $error("cpu gate");
    property p_idle_periph;
        POWER_MODE_O == 4'h2 |-> PERIPH_CLOCK_O == SYSTEM_CLOCK_O;
    endproperty
    a_idle_periph: assert property (p_idle_periph) else $error("idle periph");
    property p_idle_exit;
        POWER_MODE_O == 4'h2 && IRQ_PENDING_I |=> POWER_MODE_O == 4'h1;
    endproperty
    a_idle_exit: assert property (p_idle_exit) else $error("idle stuck");
    property p_wake;
        POWER_MODE_O == 4'h8 && wake |=> POWER_MODE_O == 4'h1;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_entry;
        (POWER_MODE_O != 4'h1 && $past(POWER_MODE_O) == 4'h1) |-> $past(INSTR_DONE_I);
    endproperty
    a_entry: assert property (p_entry) else $error("early entry");
    property p_ext_tick;
        !$past(RST_I) |-> EXT_TIMER_TICK_O == $past(EXT_OSC_TICK_I);
    endproperty
    a_ext_tick: assert property (p_ext_tick) else $error("ext tick");
    property p_xtal;
        !$past(RST_I) |-> CRYSTAL_VALID_O == $past(XTAL_SETTLED_I);
    endproperty
    a_xtal: assert property (p_xtal) else $error("xtal flag");
    property p_rdata_hold;
        !$past(RST_I) && !$past(SFR_RD_I) |-> $stable(SFR_RDATA_O);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");

    // main scenarios
    c_idle: cover property (POWER_MODE_O == 4'h1 ##1 POWER_MODE_O == 4'h2);
    c_wake: cover property (POWER_MODE_O == 4'h8 ##1 POWER_MODE_O == 4'h1);
    c_stop: cover property (POWER_MODE_O == 4'h1 ##1 POWER_MODE_O == 4'h4);
endmodule // scp_clock_power_checker

bind scp_clock_power scp_clock_power_checker u_chk (.*);

// file: sim/scp_clock_power_tb.sv
// self-checking bench for the clock and power control block
`timescale 1ns/1ns
module scp_clock_power_tb;
    import scp_pkg::*;
    localparam logic [6:0] TRIM = 7'h2A; // arbitrary trim reset value

    // ********************
    // stimulus and observed signals
    // ********************
    logic       CLK_I = 1'b0, RST_I = 1'b1, SFR_WR_I = 1'b0, SFR_RD_I = 1'b0;
    logic [7:0] SFR_ADDR_I = 8'h00, SFR_WDATA_I = 8'h00, SFR_RDATA_O;
    logic       INSTR_DONE_I = 1'b0, IRQ_PENDING_I = 1'b0, XTAL_SETTLED_I = 1'b0;
    logic       PORT0_MATCH_I = 1'b0, PORT1_MATCH_I = 1'b0, TMR3_OVF_I = 1'b0;
    logic       CMP0_ENABLED_I = 1'b0, CMP0_OUT_I = 1'b1;
    logic       FAST_OSC_TICK_I = 1'b0, EXT_OSC_TICK_I = 1'b0, SLOW_OSC_TICK_I = 1'b0, LOWPWR_OSC_TICK_I = 1'b0;
    logic       FAST_OSC_RUN_O, LOWPWR_OSC_EN_O, CRYSTAL_VALID_O, SYSTEM_CLOCK_O;
    logic       CPU_CLOCK_O, PERIPH_CLOCK_O, EXT_TIMER_TICK_O;
    logic [6:0] FAST_OSC_TRIM_O;
    logic [3:0] POWER_MODE_O;
    int         fail_count = 0, compares = 0, cyc = 0, c, p, x;
    logic [2:0] code_t [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
    int         per_t [5] = '{4, 3, 5, 2, 7};

    scp_clock_power #(.TRIM_RESET(TRIM)) dut (.*);

    // 100 MHz clock
    always #5 CLK_I = ~CLK_I;

    // source ticks; gated ones only while enabled
    always @(negedge CLK_I)
    begin
        cyc <= cyc + 1;
        FAST_OSC_TICK_I <= FAST_OSC_RUN_O && cyc[0];
        EXT_OSC_TICK_I <= (cyc % 3 == 0);
        SLOW_OSC_TICK_I <= (cyc % 5 == 0);
        LOWPWR_OSC_TICK_I <= LOWPWR_OSC_EN_O && (cyc % 7 == 0);
    end

    // ********************
    // tasks
    // ********************
    task automatic print_verdict;
        if (fail_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLK_I);
        SFR_ADDR_I = a;
        SFR_WDATA_I = d;
        SFR_WR_I = 1'b1;
        @(negedge CLK_I);
        SFR_WR_I = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge CLK_I);
        SFR_ADDR_I = a;
        SFR_RD_I = 1'b1;
        @(negedge CLK_I);
        SFR_RD_I = 1'b0;
        chk(SFR_RDATA_O, e);
    endtask
    task automatic done_pulse;
        @(negedge CLK_I);
        INSTR_DONE_I = 1'b1;
        @(negedge CLK_I);
        INSTR_DONE_I = 1'b0;
    endtask
    // cycles to next system clock pulse
    task automatic wait_sys(output int n);
        n = 0;
        do
        begin
            @(negedge CLK_I);
            n++;
        end while (SYSTEM_CLOCK_O !== 1'b1 && n < 300);
        if (n >= 300)
        begin
            fail_count++;
            print_verdict();
        end
    endtask
    task automatic chkm(input logic [3:0] e);
        chk({4'h0, POWER_MODE_O}, {4'h0, e});
    endtask
    task automatic per(input int e);
        int n;
        repeat (3) wait_sys(n);
        chk(n[7:0], e[7:0]);
    endtask
    // tick counts over 30 cycles
    task automatic window;
        c = 0;
        p = 0;
        x = 0;
        repeat (30)
        begin
            @(negedge CLK_I);
            c += (CPU_CLOCK_O === 1'b1);
            p += (PERIPH_CLOCK_O === 1'b1);
            x += (EXT_TIMER_TICK_O === 1'b1);
        end
    endtask

    // ********************
    // main sequence
    // ********************
    initial
    begin
        repeat (10) @(negedge CLK_I);
        RST_I = 1'b0;
        rd(SCP_ADDR_POWER_MODE_CONTROL, 8'h00);
        rd(SCP_ADDR_CLOCK_SOURCE_SEL, 8'h00);
        rd(SCP_ADDR_FAST_OSC_TRIM, {1'b0, TRIM});
        rd(SCP_ADDR_FAST_OSC_CONTROL, 8'hC0);
        rd(8'h55, 8'h00);
        per(32);
        wr(SCP_ADDR_FAST_OSC_TRIM, 8'hFF);
        rd(SCP_ADDR_FAST_OSC_TRIM, 8'h7F);
        chk({1'b0, FAST_OSC_TRIM_O}, 8'h7F);
        wr(SCP_ADDR_POWER_MODE_CONTROL, 8'hFC);
        rd(SCP_ADDR_POWER_MODE_CONTROL, 8'hFC);
        for (int k = 0; k < 4; k++)
        begin
            wr(SCP_ADDR_FAST_OSC_CONTROL, 8'h80 | k[7:0]);
            per(32 >> k);
        end
        for (int k = 0; k < 5; k++)
        begin
            wr(SCP_ADDR_CLOCK_SOURCE_SEL, {5'h1F, code_t[k]});
            rd(SCP_ADDR_CLOCK_SOURCE_SEL, {5'h00, code_t[k]});
            per(per_t[k]);
            chk({7'h00, LOWPWR_OSC_EN_O}, {7'h00, code_t[k] == 3'h5});
        end
        wr(SCP_ADDR_CLOCK_SOURCE_SEL, 8'h04);
        wr(SCP_ADDR_CLOCK_SOURCE_SEL, 8'h06);
        rd(SCP_ADDR_CLOCK_SOURCE_SEL, 8'h05);
        XTAL_SETTLED_I = 1'b1;
        wr(SCP_ADDR_CLOCK_SOURCE_SEL, 8'h03);
        chk({7'h00, CRYSTAL_VALID_O}, 8'h01);
        per(2);
        // idle entry, gating and exit
        wr(SCP_ADDR_POWER_MODE_CONTROL, 8'hA9);
        rd(SCP_ADDR_POWER_MODE_CONTROL, 8'hA8);
        chkm(4'h1);
        done_pulse();
        chkm(4'h2);
        window();
        chk(c[7:0], 8'h00);
        chk(p[7:0], 8'h0F);
        chk(x[7:0], 8'h0A);
        IRQ_PENDING_I = 1'b1;
        @(negedge CLK_I);
        chkm(4'h1);
        IRQ_PENDING_I = 1'b0;
        rd(SCP_ADDR_POWER_MODE_CONTROL, 8'hA8);
        // suspend with each wake event
        wr(SCP_ADDR_CLOCK_SOURCE_SEL, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            wr(SCP_ADDR_FAST_OSC_CONTROL, 8'hA0);
            done_pulse();
            chkm(4'h8);
            chk({7'h00, FAST_OSC_RUN_O}, 8'h00);
            CMP0_ENABLED_I = 1'b1;
            window();
            chk(p[7:0], 8'h00);
            chkm(4'h8);
            {PORT0_MATCH_I, PORT1_MATCH_I, TMR3_OVF_I} = {k == 0, k == 1, k == 3};
            CMP0_OUT_I = (k != 2);
            @(negedge CLK_I);
            chkm(4'h1);
            {PORT0_MATCH_I, PORT1_MATCH_I, TMR3_OVF_I, CMP0_ENABLED_I, CMP0_OUT_I} = 5'h01;
            rd(SCP_ADDR_FAST_OSC_CONTROL, 8'hC0);
        end
        // stop on fast source, left only by reset
        wr(SCP_ADDR_CLOCK_SOURCE_SEL, 8'h03);
        wr(SCP_ADDR_POWER_MODE_CONTROL, 8'h02);
        done_pulse();
        chkm(4'h4);
        PORT0_MATCH_I = 1'b1;
        window();
        PORT0_MATCH_I = 1'b0;
        chkm(4'h4);
        chk(p[7:0], 8'h00);
        chk({7'h00, FAST_OSC_RUN_O}, 8'h00);
        RST_I = 1'b1;
        @(negedge CLK_I);
        RST_I = 1'b0;
        chkm(4'h1);
        rd(SCP_ADDR_CLOCK_SOURCE_SEL, 8'h00);
        rd(SCP_ADDR_FAST_OSC_CONTROL, 8'hC0);
        rd(SCP_ADDR_POWER_MODE_CONTROL, 8'h00);
        per(32);
        print_verdict();
    end
endmodule // scp_clock_power_tb
